// ### hdl/ebi_card_nand_strobe_mux.sv
`timescale 1ns/1ps
`default_nettype none


// How the block sits in the external bus path.
// The static memory controller produces one set of low-true strobes and chip selects.
// This block decides, cycle by cycle, what each shared pin shows to the board.
// A card access is recognised only when three things agree at once.
// The slot must be assigned, the address must lie in the slot's region,
// and the slot's chip select must be low in the same cycle.
// Requiring the chip select keeps a stale address from steering the pins.
// The controller may leave the last address on the bus between accesses.
// Without the chip select term the shared pins would stay in card meaning then.
// Other memories on the shared pins would then see card strobes instead of plain ones.
//
// Card modes come from three address bits inside the card region.
// Codes that are not I/O or IDE fall back to the memory strobes.
// That choice keeps an unexpected code from ever driving the I/O strobes.
// The I/O strobes can change the state of a card register, so a read there is not harmless.
// True IDE and its alternate form behave alike on these pins.
//
// Flash steering is independent of the card steering.
// Its strobes are live only while chip select three is low in its region.
// One clock after the address leaves that region the flash strobes return high.
// The flash device tells command, address and data apart by address lines alone.
// Flash steering therefore never looks at the latch address bits.
//
// Every pin value is registered, so each pin changes one clock after its inputs.
// The register stops decode glitches from reaching the board.
// The price is one cycle of latency on every strobe and select.
// The controller waveforms are many cycles long, so the shift is harmless.
// Chip select and strobe both move by the same cycle, so their overlap is kept.
//
// Reset parks every low-true pin high and the shared address pin high too.
// No memory on the board can be selected while reset is low.
// The card direction pin is high at rest, which points the buffers towards the controller.
//
// The status outputs tell a watcher whether a card access is under way.
// They also give the decoded mode of that access.
// Outside card accesses the mode reads as zero.
module ebi_card_nand_strobe_mux
    import strobe_mux_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire static_strobes_t ctrl_strobes,
    input  wire logic [31:0]     transfer_addr,
    input  wire logic            slot0_assign_bit,
    input  wire logic            slot1_assign_bit,
    input  wire logic            flash_assign_bit,
    output pin_values_t          pins,
    output logic                 card_access,
    output logic [2:0]           card_mode
);

    // Region hits of the current transfer address.
    logic        in_slot0;
    logic        in_slot1;
    logic        in_flash;

    // A card access needs the region hit and the slot's chip select together.
    logic        card_sel;

    // Mode field of the card address space.
    logic [2:0]  mode;

    // Card strobes as the mode decoder gives them.
    logic        mem_oe_n;
    logic        mem_we_n;
    logic        io_rd_n;
    logic        io_wr_n;

    // Next values of the output registers.
    pin_values_t next_pins;
    logic        next_card_access;
    logic [2:0]  next_card_mode;

    // Region decode of the transfer address.
    always_comb begin
        in_slot0 = slot0_assign_bit
                   && transfer_addr[REGION_MSB:REGION_LSB] == REGION_SLOT0;
        in_slot1 = slot1_assign_bit
                   && transfer_addr[REGION_MSB:REGION_LSB] == REGION_SLOT1;
        in_flash = flash_assign_bit
                   && transfer_addr[REGION_MSB:REGION_LSB] == REGION_FLASH;
        card_sel = (in_slot0 && ctrl_strobes.cs4_n == STROBE_ON)
                   || (in_slot1 && ctrl_strobes.cs5_n == STROBE_ON);
        mode     = transfer_addr[MODE_MSB:MODE_LSB];
    end

    // Per-mode card strobe generation.
    // The decoder idles all four strobes when no card access is selected.
    card_mode_decode u_mode (
        .mode     (mode),
        .selected (card_sel),
        .read_n   (ctrl_strobes.read_n),
        .write0_n (ctrl_strobes.write0_n),
        .mem_oe_n (mem_oe_n),
        .mem_we_n (mem_we_n),
        .io_rd_n  (io_rd_n),
        .io_wr_n  (io_wr_n)
    );

    // Pin multiplexing: card strobes on card access, plain strobes otherwise.
    // Defaults park every pin high so that no path can leave a pin undriven.
    always_comb begin
        next_pins = '{default: STROBE_OFF};
        if (card_sel) begin
            next_pins.read_oe_n       = mem_oe_n;
            next_pins.write0_we_n     = mem_we_n;
            next_pins.byte1_ioread_n  = io_rd_n;
            next_pins.byte3_iowrite_n = io_wr_n;
            next_pins.a25_rnw         = ctrl_strobes.write0_n;
        end else begin
            next_pins.read_oe_n       = ctrl_strobes.read_n;
            next_pins.write0_we_n     = ctrl_strobes.write0_n;
            next_pins.byte1_ioread_n  = ctrl_strobes.byte1_n;
            next_pins.byte3_iowrite_n = ctrl_strobes.byte3_n;
            next_pins.a25_rnw         = transfer_addr[ADDR_SHARED_BIT];
        end
        // Chip select pins: slot selects share chip select timing.
        next_pins.cs4_slot0_n = ctrl_strobes.cs4_n;
        next_pins.cs5_slot1_n = ctrl_strobes.cs5_n;
        if (card_sel) begin
            next_pins.byte_enable_low_n  = ctrl_strobes.byte0_n;
            next_pins.byte_enable_high_n = ctrl_strobes.byte1_n;
        end
        // Flash strobes only while chip select three is active in its region.
        if (in_flash && ctrl_strobes.cs3_n == STROBE_ON) begin
            next_pins.flash_oe_n = ctrl_strobes.read_n;
            next_pins.flash_we_n = ctrl_strobes.write0_n;
        end
        next_card_access = card_sel;
        next_card_mode   = card_sel ? mode : MODE_ATTRIB;
    end

    // Output registers; reset leaves every strobe inactive high.
    // Every output comes straight from these flip-flops, so no decode glitch escapes.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pins        <= '{default: STROBE_OFF};
            card_access <= 1'b0;
            card_mode   <= MODE_ATTRIB;
        end else begin
            pins        <= next_pins;
            card_access <= next_card_access;
            card_mode   <= next_card_mode;
        end
    end

endmodule

`default_nettype wire

// ### hdl/strobe_mux_pkg.sv
package strobe_mux_pkg;

    // Transfer address regions, top nibble of the 32-bit system address.
    localparam logic [3:0] REGION_FLASH = 4'h4;
    localparam logic [3:0] REGION_SLOT0 = 4'h5;
    localparam logic [3:0] REGION_SLOT1 = 4'h6;
    localparam int         REGION_MSB   = 31;
    localparam int         REGION_LSB   = 28;

    // Mode field position in the transfer address.
    localparam int MODE_MSB = 23;
    localparam int MODE_LSB = 21;

    // Mode codes of the card address space.
    localparam logic [2:0] MODE_ATTRIB  = 3'h0;
    localparam logic [2:0] MODE_COMMON  = 3'h2;
    localparam logic [2:0] MODE_IO      = 3'h4;
    localparam logic [2:0] MODE_IDE     = 3'h6;
    localparam logic [2:0] MODE_ALT_IDE = 3'h7;

    // Inactive and active levels of the low-true strobes.
    localparam logic STROBE_OFF = 1'b1;
    localparam logic STROBE_ON  = 1'b0;

    // Address bit that shares its pin with the card direction signal.
    localparam int ADDR_SHARED_BIT = 25;

    // Strobes coming from the static memory controller, all active low.
    typedef struct packed {
        logic read_n;
        logic write0_n;
        logic byte0_n;
        logic byte1_n;
        logic byte3_n;
        logic cs3_n;
        logic cs4_n;
        logic cs5_n;
    } static_strobes_t;

    // Values presented on the shared and dedicated pins.
    typedef struct packed {
        logic read_oe_n;
        logic write0_we_n;
        logic byte1_ioread_n;
        logic byte3_iowrite_n;
        logic a25_rnw;
        logic cs4_slot0_n;
        logic cs5_slot1_n;
        logic byte_enable_low_n;
        logic byte_enable_high_n;
        logic flash_oe_n;
        logic flash_we_n;
    } pin_values_t;

endpackage

// ### hdl/card_mode_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Decodes the card access mode and gives the four card strobes for one slot.
module card_mode_decode
    import strobe_mux_pkg::*;
(
    input  wire logic [2:0] mode,
    input  wire logic       selected,
    input  wire logic       read_n,
    input  wire logic       write0_n,
    output logic            mem_oe_n,
    output logic            mem_we_n,
    output logic            io_rd_n,
    output logic            io_wr_n
);

    // Strobe steering by mode; everything idle when the slot is not selected.
    always_comb begin
        mem_oe_n = STROBE_OFF;
        mem_we_n = STROBE_OFF;
        io_rd_n  = STROBE_OFF;
        io_wr_n  = STROBE_OFF;
        if (selected) begin
            case (mode)
                MODE_IO: begin
                    io_rd_n = read_n;
                    io_wr_n = write0_n;
                end
                MODE_IDE, MODE_ALT_IDE: begin
                    mem_oe_n = STROBE_ON;
                    io_rd_n  = read_n;
                    io_wr_n  = write0_n;
                end
                default: begin
                    mem_oe_n = read_n;
                    mem_we_n = write0_n;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### tb/strobe_mux_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Checks pin steering one cycle after the sampled inputs.
module strobe_mux_assertions
    import strobe_mux_pkg::*;
(
    input wire logic            clk_sys,
    input wire logic            rst_n,
    input wire static_strobes_t ctrl_strobes,
    input wire logic [31:0]     transfer_addr,
    input wire logic            slot0_assign_bit,
    input wire logic            slot1_assign_bit,
    input wire logic            flash_assign_bit,
    input wire pin_values_t     pins,
    input wire logic            card_access,
    input wire logic [2:0]      card_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic up;
    // Up is set once an edge after reset has loaded the outputs.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up <= 1'b0;
        end else begin
            up <= 1'b1;
        end
    end
    a_slot_sel_pass: assert property (up |-> pins.cs4_slot0_n == $past(ctrl_strobes.cs4_n)
        && pins.cs5_slot1_n == $past(ctrl_strobes.cs5_n)) else $error("slot select differs");
    a_io_mem_idle: assert property (card_access && card_mode inside {3'h4, 3'h6, 3'h7}
        |-> pins.write0_we_n && pins.byte1_ioread_n == $past(ctrl_strobes.read_n))
        else $error("io mode strobes wrong");
    a_mem_io_idle: assert property (card_access && !(card_mode inside {3'h4, 3'h6, 3'h7})
        |-> pins.byte1_ioread_n && pins.byte3_iowrite_n) else $error("memory mode io active");
    a_io_oe_level: assert property (card_access && card_mode[2] && card_mode != 3'h5
        |-> pins.read_oe_n == !card_mode[1]) else $error("io or ide oe level wrong");
    a_plain_share: assert property (up && !card_access |-> pins.a25_rnw == $past(transfer_addr[25])
        && pins.byte3_iowrite_n == $past(ctrl_strobes.byte3_n)) else $error("plain pins wrong");
    a_card_rnw: assert property (card_access |-> pins.a25_rnw == $past(ctrl_strobes.write0_n))
        else $error("card direction wrong");
    a_card_decode: assert property (up |-> card_access == $past(slot0_assign_bit
        && transfer_addr[31:28] == REGION_SLOT0 && !ctrl_strobes.cs4_n || slot1_assign_bit
        && transfer_addr[31:28] == REGION_SLOT1 && !ctrl_strobes.cs5_n)) else $error("decode wrong");
    a_byte_en: assert property (up |-> pins.byte_enable_low_n
        == (!card_access || $past(ctrl_strobes.byte0_n))) else $error("byte enable wrong");
    a_flash_steer: assert property (up |-> pins.flash_oe_n == (!$past(flash_assign_bit
        && transfer_addr[31:28] == REGION_FLASH && !ctrl_strobes.cs3_n) || $past(ctrl_strobes.read_n)))
        else $error("flash strobe wrong");
    // Main scenarios seen.
    c_ide: cover property (card_access && card_mode == MODE_IDE);
    c_common: cover property (card_access && card_mode == MODE_COMMON);
    c_flash: cover property (!pins.flash_we_n);
endmodule
`default_nettype wire

// ### tb/card_flash_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Far side model: flash counts write strobes, card data is told apart by address only.
module card_flash_partner
    import strobe_mux_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire pin_values_t pins,
    output int               flash_writes
);
    logic ce_n;
    logic ready;
    logic wait_n;
    assign ce_n   = 1'b0; // Chip enable held low by a general purpose pin.
    assign ready  = 1'b1; // Ready/busy read on a general purpose input; always ready.
    assign wait_n = 1'b1; // Card wait goes to the controller, never stretches here.
    // Word kind depends on latch address lines only, not on the strobes.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flash_writes <= 0;
        end else begin
            flash_writes <= flash_writes + int'(!pins.flash_we_n && !ce_n && ready && wait_n);
        end
    end
endmodule
`default_nettype wire

// ### tb/ebi_card_nand_strobe_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ebi_card_nand_strobe_mux_tb_top;
    import strobe_mux_pkg::*;
    typedef struct packed {pin_values_t p; logic a; logic [2:0] m;} exp_t;
    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    static_strobes_t st = '1;
    logic [31:0]     addr = '0;
    logic [2:0]      bits = '0;
    pin_values_t     pins;
    logic            card_access;
    logic [2:0]      card_mode;
    int              err_count = 0;
    int              tests_run = 0;
    int              fw;
    int              fw_exp = 0;
    exp_t            q[$];
    ebi_card_nand_strobe_mux i_ebi_card_nand_strobe_mux (.clk_sys(clk_sys), .rst_n(rst_n),
        .ctrl_strobes(st), .transfer_addr(addr), .slot0_assign_bit(bits[0]),
        .slot1_assign_bit(bits[1]), .flash_assign_bit(bits[2]), .pins(pins),
        .card_access(card_access), .card_mode(card_mode));
    card_flash_partner i_card_flash_partner (.clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
        .flash_writes(fw));
    // Expected pins worked out from the steering rules.
    function automatic exp_t model(static_strobes_t s, logic [31:0] a, logic [2:0] b);
        exp_t e;
        logic c, io, ide, f;
        c = b[0] && a[31:28] == 4'h5 && !s.cs4_n || b[1] && a[31:28] == 4'h6 && !s.cs5_n;
        io = c && a[23:21] inside {3'h4, 3'h6, 3'h7};
        ide = c && a[23:22] == 2'h3;
        f = b[2] && a[31:28] == 4'h4 && !s.cs3_n;
        e.p.read_oe_n = io ? !ide : s.read_n;
        e.p.write0_we_n = io | s.write0_n;
        e.p.byte1_ioread_n = c ? (!io | s.read_n) : s.byte1_n;
        e.p.byte3_iowrite_n = c ? (!io | s.write0_n) : s.byte3_n;
        e.p.a25_rnw = c ? s.write0_n : a[25];
        e.p.cs4_slot0_n = s.cs4_n;
        e.p.cs5_slot1_n = s.cs5_n;
        e.p.byte_enable_low_n = !c | s.byte0_n;
        e.p.byte_enable_high_n = !c | s.byte1_n;
        e.p.flash_oe_n = !f | s.read_n;
        e.p.flash_we_n = !f | s.write0_n;
        e.a = c;
        e.m = c ? a[23:21] : 3'h0;
        return e;
    endfunction
    task automatic cmp(exp_t e, exp_t g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic cmp_count(int e, int g);
        tests_run++;
        if (g != e) begin
            err_count++;
            $display("mismatch at %0t: flash writes got %0d want %0d", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial forever #20 clk_sys = ~clk_sys;
    // Outputs settle just after the edge; the oldest note is compared then.
    always @(posedge clk_sys) begin
        #1;
        if (q.size() > 0) cmp(q.pop_front(), {pins, card_access, card_mode});
    end
    // Random traffic over flash, both card regions and a plain region.
    // Modes come only from the address, as the controller timing would choose them.
    // Flash latch bits 21 and 22 ride in the random address.
    // Region 0x7 stands for other memories; card select pins pass the chip selects in every region.
    // Dynamic RAM width and set-up are not on these pins and stay idle.
    initial begin
        void'($urandom(26));
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (800) begin
            st = static_strobes_t'($urandom);
            addr = {4'h4 + 4'($urandom_range(3)), 28'($urandom)};
            bits = 3'($urandom);
            q.push_back(model(st, addr, bits));
            fw_exp += int'(!q[$].p.flash_we_n);
            @(negedge clk_sys);
        end
        @(posedge clk_sys);
        #2;
        cmp_count(fw_exp, fw);
        @(negedge clk_sys);
        rst_n = 1'b0;
        #1;
        cmp({11'h7ff, 1'b0, 3'h0}, {pins, card_access, card_mode});
        summarize();
    end
    initial begin
        #60000;
        err_count++;
        summarize();
    end
endmodule
bind ebi_card_nand_strobe_mux strobe_mux_assertions i_strobe_mux_assertions (.clk_sys(clk_sys),
    .rst_n(rst_n), .ctrl_strobes(ctrl_strobes), .transfer_addr(transfer_addr),
    .slot0_assign_bit(slot0_assign_bit), .slot1_assign_bit(slot1_assign_bit),
    .flash_assign_bit(flash_assign_bit), .pins(pins), .card_access(card_access),
    .card_mode(card_mode));
`default_nettype wire
